// [verilog/ccs_calibration_sequencer.sv]
// Purpose: calibration command sequencer of a multi-channel measurement unit
// Assumes: commands are parsed upstream into a code plus value strobe
// Notes:   analogue steps are requested on handshake outputs
//
// Functional notes
// - converter calibration gathers gains for all five ranges and the cal resistor value for storage.
// - converter offset zeroing runs only on the zero query, never while scanning.
// - either channel-calibration command runs offset, gain and current-source correction on board.
// - tare takes the shorted-channel reading as the new zero and applies it at once.
// - a tare runs a full channel calibration in the same operation, unless store_tare_in is set, which only stores the tare.
// - remote units zero with shorting switches and set gain from their own source.
// - resistance configure puts the reference resistor on the cal bus for four-wire use.
// - configure commands are refused while the trigger system is initiated.
// - the configure range must lie within five percent of a nominal range.
// - the range may be given in microvolts or millivolts.
// - full scale gives about ninety percent of range, ten volts on the top range.
// - zero or full scale is selected; range picks the range recorded, and sets the level only for full scale.
`timescale 1ns/1ps
`default_nettype none
module ccs_calibration_sequencer
    import ccs_pkg::*;
#(
    parameter int SETTLE_CYC = CCS_SETTLE_CYC
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 srst_in,
    // command port
    input  wire logic                 cmd_valid_in,
    input  wire logic [3:0]           cmd_code_in,
    input  wire logic [CCS_VAL_W-1:0] cmd_value_in,
    input  wire logic                 cmd_value_mv_in,
    input  wire logic                 full_scale_select_in,
    input  wire logic                 store_tare_in,
    input  wire logic                 initiated_in,
    input  wire logic                 err_read_in,
    // analogue step handshake
    input  wire logic                 step_done_in,
    input  wire logic [CCS_VAL_W-1:0] step_result_in,
    // status
    output logic                      busy_out,
    output logic                      op_complete_out,
    output logic [3:0]                err_code_out,
    // cal bus routing
    output logic                      connect_ref_resistor_out,
    output logic                      connect_ref_voltage_out,
    output logic [CCS_VAL_W-1:0]      source_level_uv_out,
    // analogue step requests
    output logic                      adc_zero_req_out,
    output logic                      chan_cal_req_out,
    output logic                      remote_short_req_out,
    output logic                      remote_gain_req_out,
    output logic                      nv_store_req_out,
    output logic                      nv_store_tare_out,
    // calibration results
    output logic [CCS_VAL_W-1:0]      tare_offset_out,
    output logic [CCS_VAL_W-1:0]      ref_ohms_out,
    output logic [CCS_NUM_RANGES-1:0] gains_valid_out
);

    if (SETTLE_CYC < 1) begin : g_settle_chk
        $error("SETTLE_CYC must be at least 1");
    end

    // range match within 5 %: returns index, or NUM_RANGES on miss
    function automatic logic [2:0] range_index(input logic [31:0] uv);
        logic [2:0]  idx;
        logic [31:0] tol;
        idx = 3'(CCS_NUM_RANGES);
        for (int i = 0; i < CCS_NUM_RANGES; i++) begin
            tol = CCS_RANGE_UV[i] / 32'd20;
            if (uv >= CCS_RANGE_UV[i] - tol && uv <= CCS_RANGE_UV[i] + tol) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    ccs_state_t                  state_r, state_nxt;
    ccs_bus_t                    bus_r, bus_nxt;
    logic [31:0]                 level_nxt, cnt_r, cnt_nxt, uv;
    logic [2:0]                  range_r, range_nxt, ridx;
    logic                        fs_r, fs_nxt, done_nxt;
    logic [3:0]                  err_nxt;
    logic [CCS_VAL_W-1:0]        tare_nxt, ohms_nxt;
    logic [CCS_NUM_RANGES-1:0]   zero_got_r, zero_got_nxt;
    logic [CCS_NUM_RANGES-1:0]   fs_got_r, fs_got_nxt;
    logic                        ohms_got_r, ohms_got_nxt;
    logic                        store_nxt, store_tare_nxt;

    always_comb begin
        uv = cmd_value_mv_in ? cmd_value_in * CCS_MV_TO_UV : cmd_value_in;
        ridx = range_index(uv);
        state_nxt = state_r;
        bus_nxt = bus_r;
        level_nxt = source_level_uv_out;
        cnt_nxt = cnt_r;
        range_nxt = range_r;
        fs_nxt = fs_r;
        done_nxt = op_complete_out;
        err_nxt = err_code_out;
        tare_nxt = tare_offset_out;
        ohms_nxt = ref_ohms_out;
        zero_got_nxt = zero_got_r;
        fs_got_nxt = fs_got_r;
        ohms_got_nxt = ohms_got_r;
        store_nxt = nv_store_req_out;
        store_tare_nxt = nv_store_tare_out;
        // a new error wins over the read-clear in the same cycle
        if (err_read_in) begin
            err_nxt = CCS_ERR_NONE;
        end
        case (state_r)
            CCS_ST_IDLE: begin
                if (cmd_valid_in) begin
                    done_nxt = 1'b0;
                    case (ccs_cmd_t'(cmd_code_in))
                        CCS_CMD_CONF_RES, CCS_CMD_CONF_VOLT: begin
                            if (initiated_in) begin
                                err_nxt = CCS_ERR_INIT;
                                done_nxt = 1'b1;
                            end else if (ccs_cmd_t'(cmd_code_in)
                                         == CCS_CMD_CONF_RES) begin
                                bus_nxt = CCS_BUS_RES;
                                level_nxt = '0;
                                cnt_nxt = 32'(SETTLE_CYC);
                                state_nxt = CCS_ST_SETTLE;
                            end else if (ridx == 3'(CCS_NUM_RANGES)) begin
                                err_nxt = CCS_ERR_RANGE;
                                done_nxt = 1'b1;
                            end else begin
                                bus_nxt = CCS_BUS_VOLT;
                                range_nxt = ridx;
                                fs_nxt = full_scale_select_in;
                                // range only shapes the full-scale level
                                level_nxt = full_scale_select_in
                                    ? CCS_FS_UV[ridx] : '0;
                                cnt_nxt = 32'(SETTLE_CYC);
                                state_nxt = CCS_ST_SETTLE;
                            end
                        end
                        CCS_CMD_VAL_RES: begin
                            if (bus_r == CCS_BUS_RES) begin
                                ohms_nxt = cmd_value_in;
                                ohms_got_nxt = 1'b1;
                            end else begin
                                err_nxt = CCS_ERR_SEQUENCE;
                            end
                            done_nxt = 1'b1;
                        end
                        CCS_CMD_VAL_VOLT: begin
                            if (bus_r != CCS_BUS_VOLT) begin
                                err_nxt = CCS_ERR_SEQUENCE;
                            end else if (fs_r) begin
                                fs_got_nxt[range_r] = 1'b1;
                            end else begin
                                zero_got_nxt[range_r] = 1'b1;
                            end
                            done_nxt = 1'b1;
                        end
                        CCS_CMD_STORE_ADC: begin
                            // constants are complete only with all ranges
                            if (&zero_got_r && &fs_got_r && ohms_got_r) begin
                                bus_nxt = CCS_BUS_OPEN;
                                store_nxt = 1'b1;
                                store_tare_nxt = 1'b0;
                                state_nxt = CCS_ST_STORE;
                            end else begin
                                err_nxt = CCS_ERR_SEQUENCE;
                                done_nxt = 1'b1;
                            end
                        end
                        CCS_CMD_ZERO: begin
                            state_nxt = CCS_ST_ZERO;
                        end
                        CCS_CMD_CHAN_CAL, CCS_CMD_CHAN_SET: begin
                            state_nxt = CCS_ST_CHCAL;
                        end
                        CCS_CMD_TARE: begin
                            if (store_tare_in) begin
                                store_nxt = 1'b1;
                                store_tare_nxt = 1'b1;
                                state_nxt = CCS_ST_STORE;
                            end else begin
                                state_nxt = CCS_ST_TARE;
                            end
                        end
                        CCS_CMD_REMOTE: begin
                            cnt_nxt = '0;
                            state_nxt = CCS_ST_REM;
                        end
                        default: begin
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            CCS_ST_SETTLE: begin
                if (cnt_r <= 32'd1) begin
                    done_nxt = 1'b1;
                    state_nxt = CCS_ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 32'd1;
                end
            end
            CCS_ST_ZERO, CCS_ST_CHCAL, CCS_ST_STORE: begin
                if (step_done_in) begin
                    store_nxt = 1'b0;
                    done_nxt = 1'b1;
                    state_nxt = CCS_ST_IDLE;
                end
            end
            CCS_ST_TARE: begin
                if (step_done_in) begin
                    tare_nxt = step_result_in;
                    state_nxt = CCS_ST_CHCAL;
                end
            end
            CCS_ST_REM: begin
                // phase 0 shorts inputs, phase 1 drives gain source
                if (step_done_in) begin
                    if (cnt_r == 32'd0) begin
                        cnt_nxt = 32'd1;
                    end else begin
                        done_nxt = 1'b1;
                        state_nxt = CCS_ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = CCS_ST_IDLE;
            end
        endcase
    end

    // output flops double as command state, so no shadow copies to skew
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r                  <= CCS_ST_IDLE;
            bus_r                    <= CCS_BUS_OPEN;
            cnt_r                    <= '0;
            range_r                  <= '0;
            fs_r                     <= 1'b0;
            zero_got_r               <= '0;
            fs_got_r                 <= '0;
            ohms_got_r               <= 1'b0;
            busy_out                 <= 1'b0;
            op_complete_out          <= 1'b1;
            err_code_out             <= CCS_ERR_NONE;
            connect_ref_resistor_out <= 1'b0;
            connect_ref_voltage_out  <= 1'b0;
            source_level_uv_out      <= '0;
            adc_zero_req_out         <= 1'b0;
            chan_cal_req_out         <= 1'b0;
            remote_short_req_out     <= 1'b0;
            remote_gain_req_out      <= 1'b0;
            nv_store_req_out         <= 1'b0;
            nv_store_tare_out        <= 1'b0;
            tare_offset_out          <= '0;
            ref_ohms_out             <= '0;
            gains_valid_out          <= '0;
        end else begin
            state_r                  <= state_nxt;
            bus_r                    <= bus_nxt;
            cnt_r                    <= cnt_nxt;
            range_r                  <= range_nxt;
            fs_r                     <= fs_nxt;
            zero_got_r               <= zero_got_nxt;
            fs_got_r                 <= fs_got_nxt;
            ohms_got_r               <= ohms_got_nxt;
            busy_out                 <= state_nxt != CCS_ST_IDLE;
            op_complete_out          <= done_nxt;
            err_code_out             <= err_nxt;
            connect_ref_resistor_out <= bus_nxt == CCS_BUS_RES;
            connect_ref_voltage_out  <= bus_nxt == CCS_BUS_VOLT;
            source_level_uv_out      <= level_nxt;
            adc_zero_req_out         <= state_nxt == CCS_ST_ZERO;
            chan_cal_req_out         <= state_nxt == CCS_ST_CHCAL
                                     || state_nxt == CCS_ST_TARE;
            remote_short_req_out     <= state_nxt == CCS_ST_REM
                                     && cnt_nxt == 32'd0;
            remote_gain_req_out      <= state_nxt == CCS_ST_REM
                                     && cnt_nxt == 32'd1;
            nv_store_req_out         <= store_nxt;
            nv_store_tare_out        <= store_tare_nxt;
            tare_offset_out          <= tare_nxt;
            ref_ohms_out             <= ohms_nxt;
            gains_valid_out          <= zero_got_nxt & fs_got_nxt;
        end
    end

endmodule
`default_nettype wire

// [pkg/ccs_pkg.sv]
// Purpose: constants and types for the calibration command sequencer
// Assumes: 20 MHz clock; commands arrive as decoded one-cycle strobes
// Notes:   voltages in microvolts, resistance in milliohms
package ccs_pkg;

    // command codes
    typedef enum logic [3:0] {
        CCS_CMD_NONE      = 4'b0000,
        CCS_CMD_CONF_RES  = 4'b0001,
        CCS_CMD_CONF_VOLT = 4'b0010,
        CCS_CMD_VAL_RES   = 4'b0011,
        CCS_CMD_VAL_VOLT  = 4'b0100,
        CCS_CMD_STORE_ADC = 4'b0101,
        CCS_CMD_ZERO      = 4'b0110,
        CCS_CMD_CHAN_CAL  = 4'b0111,
        CCS_CMD_CHAN_SET  = 4'b1000,
        CCS_CMD_TARE      = 4'b1001,
        CCS_CMD_REMOTE    = 4'b1010
    } ccs_cmd_t;

    typedef enum logic [2:0] {
        CCS_ST_IDLE  = 3'b000,
        CCS_ST_SETTLE = 3'b001,
        CCS_ST_ZERO  = 3'b010,
        CCS_ST_TARE  = 3'b011,
        CCS_ST_CHCAL = 3'b100,
        CCS_ST_REM   = 3'b101,
        CCS_ST_STORE = 3'b110
    } ccs_state_t;

    // calibration bus connection
    typedef enum logic [1:0] {
        CCS_BUS_OPEN = 2'b00,
        CCS_BUS_RES  = 2'b01,
        CCS_BUS_VOLT = 2'b10
    } ccs_bus_t;

    // error codes
    localparam logic [3:0] CCS_ERR_NONE     = 4'h0;
    localparam logic [3:0] CCS_ERR_INIT     = 4'h1;
    localparam logic [3:0] CCS_ERR_RANGE    = 4'h2;
    localparam logic [3:0] CCS_ERR_SEQUENCE = 4'h3;

    localparam int CCS_NUM_RANGES = 5;
    localparam int CCS_VAL_W      = 32;

    // nominal ranges, microvolts
    localparam logic [31:0] CCS_RANGE_UV [CCS_NUM_RANGES] = '{
        32'h0000_F424, 32'h0003_D090, 32'h000F_4240,
        32'h003D_0900, 32'h00F4_2400};
    // full-scale source levels, microvolts (90 %, 10 V on top range)
    localparam logic [31:0] CCS_FS_UV [CCS_NUM_RANGES] = '{
        32'h0000_DBBA, 32'h0003_6EE8, 32'h000D_BBA0,
        32'h0036_EE80, 32'h0098_9680};
    localparam logic [31:0] CCS_MV_TO_UV = 32'h0000_03E8;

    // timing
    localparam int CCS_CLK_HZ        = 20_000_000;
    localparam int CCS_SETTLE_US     = 100;
    localparam int CCS_SETTLE_CYC    = CCS_SETTLE_US * (CCS_CLK_HZ / 1_000_000);
    localparam int CCS_STEP_CYC      = 16;

endpackage

// [test/ccs_calibration_sequencer_checker.sv]
// Purpose: port-level checks of the calibration command sequencer
// Assumes: a command is taken on a rising edge while busy_out is low
// Notes:   bound onto every instance of the sequencer
`timescale 1ns/1ps
`default_nettype none
module ccs_calibration_sequencer_checker
    import ccs_pkg::*;
(
    // clock and reset
    input wire logic                 clk_in,
    input wire logic                 srst_in,
    // command port
    input wire logic                 cmd_valid_in,
    input wire logic [3:0]           cmd_code_in,
    input wire logic [CCS_VAL_W-1:0] cmd_value_in,
    input wire logic                 cmd_value_mv_in,
    input wire logic                 full_scale_select_in,
    input wire logic                 store_tare_in,
    input wire logic                 initiated_in,
    input wire logic                 step_done_in,
    // watched outputs
    input wire logic                 busy_out,
    input wire logic [3:0]           err_code_out,
    input wire logic                 connect_ref_resistor_out,
    input wire logic                 connect_ref_voltage_out,
    input wire logic [CCS_VAL_W-1:0] source_level_uv_out,
    input wire logic                 adc_zero_req_out,
    input wire logic                 chan_cal_req_out,
    input wire logic                 remote_short_req_out,
    input wire logic                 remote_gain_req_out
);
    logic tk;
    logic cfg;
    assign tk  = cmd_valid_in && !busy_out;
    assign cfg = (cmd_code_in == CCS_CMD_CONF_RES) ||
                 (cmd_code_in == CCS_CMD_CONF_VOLT);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_refuse_keep_bus: assert property (tk && initiated_in && cfg
        |=> $stable(connect_ref_resistor_out) && $stable(connect_ref_voltage_out)
        && err_code_out == CCS_ERR_INIT) else $error("initiated cfg taken");
    a_range_reject: assert property (tk && !initiated_in
        && cmd_code_in == CCS_CMD_CONF_VOLT && !cmd_value_mv_in
        && cmd_value_in >= 32'h0110_0000 |=> $stable(connect_ref_voltage_out)
        && err_code_out == CCS_ERR_RANGE) else $error("bad range taken");
    a_res_connect: assert property (tk && !initiated_in
        && cmd_code_in == CCS_CMD_CONF_RES
        |=> connect_ref_resistor_out && !connect_ref_voltage_out)
        else $error("resistor not routed");
    a_zero_level: assert property (tk && !initiated_in && !full_scale_select_in
        && cmd_code_in == CCS_CMD_CONF_VOLT && !cmd_value_mv_in
        && cmd_value_in == 32'h000F_4240 |=> connect_ref_voltage_out
        && source_level_uv_out == 32'h0000_0000) else $error("zero level");
    a_top_level: assert property (tk && !initiated_in && full_scale_select_in
        && cmd_code_in == CCS_CMD_CONF_VOLT && !cmd_value_mv_in
        && cmd_value_in == 32'h00F4_2400
        |=> source_level_uv_out == 32'h0098_9680) else $error("top level");
    a_zero_cause: assert property ($rose(adc_zero_req_out)
        |-> $past(tk && cmd_code_in == CCS_CMD_ZERO))
        else $error("zeroing without query");
    a_chan_cal_start: assert property (tk && (cmd_code_in == CCS_CMD_CHAN_CAL
        || cmd_code_in == CCS_CMD_CHAN_SET
        || (cmd_code_in == CCS_CMD_TARE && !store_tare_in))
        |=> chan_cal_req_out) else $error("channel cal not started");
    a_req_holds: assert property (chan_cal_req_out && !step_done_in
        |=> chan_cal_req_out) else $error("request dropped early");
    a_remote_phase: assert property (tk && cmd_code_in == CCS_CMD_REMOTE
        |=> remote_short_req_out && !remote_gain_req_out)
        else $error("remote not shorting first");
    a_val_no_bus: assert property (tk && cmd_code_in == CCS_CMD_VAL_VOLT
        && !connect_ref_voltage_out |=> err_code_out == CCS_ERR_SEQUENCE)
        else $error("value accepted without source");
endmodule
bind ccs_calibration_sequencer ccs_calibration_sequencer_checker u_chk (.*);
`default_nettype wire

// [test/ccs_step_partner.sv]
// Purpose: analogue side answering the sequencer's step requests
// Assumes: one request line, the or of all step requests
// Notes:   result toggles when not presented, so stale reads show up
`timescale 1ns/1ps
`default_nettype none
module ccs_step_partner
    import ccs_pkg::*;
(
    // clock
    input  wire logic                 clk_in,
    // request side
    input  wire logic                 req_in,
    input  wire logic [3:0]           delay_in,
    input  wire logic [CCS_VAL_W-1:0] short_uv_in,
    // answer side
    output logic                      step_done_out,
    output logic [CCS_VAL_W-1:0]      step_result_out
);
    int cnt;
    // one idle cycle after each pulse lets a finished request drop
    always @(posedge clk_in) begin
        step_done_out <= 1'b0;
        if (req_in && !step_done_out && cnt >= delay_in) begin
            step_done_out   <= 1'b1;
            step_result_out <= short_uv_in;
            cnt = 0;
        end else begin
            if (req_in && !step_done_out) cnt = cnt + 1;
            step_result_out <= ~step_result_out;
        end
    end
endmodule
`default_nettype wire

// [test/ccs_calibration_sequencer_tb_top.sv]
// Purpose: self-checking bench of the calibration command sequencer
// Assumes: settle count shortened to 4 cycles
// Notes:   driver queues expected state, monitor compares on completion
`timescale 1ns/1ps
`default_nettype none
module ccs_calibration_sequencer_tb_top;
    import ccs_pkg::*;
    localparam int SETTLE = 4;
    typedef struct packed {
        logic [3:0] err; logic res; logic volt; logic lvl_chk;
        logic [31:0] lvl; logic [4:0] gains; logic [31:0] tare;
        logic [31:0] ohms;
    } ccs_exp_t;
    logic        clk_in, srst_in, cmd_valid, cmd_mv, fs_sel, st_tare;
    logic        initiated, err_read, step_done, busy_out, op_complete_out;
    logic [3:0]  cmd_code, err_code_out, pdelay;
    logic [31:0] cmd_value, step_result, source_level_uv_out, short_uv;
    logic [31:0] tare_offset_out, ref_ohms_out, rv;
    logic        res_out, volt_out, zr, cr, rs, rg, nv, nvt;
    logic [4:0]  gains_valid_out;
    ccs_exp_t    cur, e, q[$];
    int          error_cnt, check_count, seed, age, n, p;
    bit          pend, mvs;

    ccs_calibration_sequencer #(.SETTLE_CYC(SETTLE)) DUT (
        .clk_in(clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid),
        .cmd_code_in(cmd_code), .cmd_value_in(cmd_value),
        .cmd_value_mv_in(cmd_mv), .full_scale_select_in(fs_sel),
        .store_tare_in(st_tare), .initiated_in(initiated),
        .err_read_in(err_read), .step_done_in(step_done),
        .step_result_in(step_result), .busy_out(busy_out),
        .op_complete_out(op_complete_out), .err_code_out(err_code_out),
        .connect_ref_resistor_out(res_out), .connect_ref_voltage_out(volt_out),
        .source_level_uv_out(source_level_uv_out), .adc_zero_req_out(zr),
        .chan_cal_req_out(cr), .remote_short_req_out(rs),
        .remote_gain_req_out(rg), .nv_store_req_out(nv),
        .nv_store_tare_out(nvt), .tare_offset_out(tare_offset_out),
        .ref_ohms_out(ref_ohms_out), .gains_valid_out(gains_valid_out));
    ccs_step_partner u_far (.clk_in(clk_in), .req_in(zr | cr | rs | rg | nv),
        .delay_in(pdelay), .short_uv_in(short_uv), .step_done_out(step_done),
        .step_result_out(step_result));

    always #25 clk_in = ~clk_in;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // bump fires a second command while busy; it must be ignored
    task automatic send(input ccs_cmd_t c, input logic [31:0] v,
                        input logic mv, input logic fs, input logic bump);
        q.push_back(cur);
        pdelay = 4'($random(seed) & 7);
        @(posedge clk_in); #2;
        cmd_valid = 1; cmd_code = c; cmd_value = v; cmd_mv = mv; fs_sel = fs;
        @(posedge clk_in); #2;
        cmd_valid = 0;
        if (bump) begin
            @(posedge clk_in); #2;
            cmd_valid = 1; cmd_code = CCS_CMD_CONF_RES;
            @(posedge clk_in); #2;
            cmd_valid = 0;
        end
        n = 0;
        while (q.size() != 0 && n < 400) begin
            @(posedge clk_in);
            #2 n++;
        end
        if (n >= 400) begin
            error_cnt++;
            $display("[ERR] %0t no completion", $time);
            complete_run();
        end
    endtask
    task automatic clr_err();
        @(posedge clk_in); #2 err_read = 1;
        @(posedge clk_in); #2 err_read = 0;
        cur.err = CCS_ERR_NONE;
    endtask

    always @(negedge clk_in) begin
        if (pend) age++;
        if (pend && age >= 2 && busy_out === 1'b0 && op_complete_out === 1'b1)
        begin
            e = q.pop_front();
            pend = 0;
            cmp(32'(err_code_out), 32'(e.err));
            cmp(32'({nvt, res_out, volt_out}),
                32'({st_tare, e.res, e.volt}));
            if (e.lvl_chk) cmp(source_level_uv_out, e.lvl);
            cmp(32'(gains_valid_out), 32'(e.gains));
            cmp(tare_offset_out, e.tare);
            cmp(ref_ohms_out, e.ohms);
        end
        if (cmd_valid && busy_out === 1'b0 && !srst_in) begin
            pend = 1;
            age = 0;
        end
    end

    initial begin
        #(50 * 30000);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        clk_in = 0; srst_in = 1; cmd_valid = 0; cmd_code = 4'h0; cmd_mv = 0;
        cmd_value = 32'h0000_0000; fs_sel = 0; st_tare = 0; initiated = 0;
        err_read = 0; pdelay = 4'h0; short_uv = 32'h0000_0000;
        error_cnt = 0; check_count = 0; seed = 32'hbbc7; pend = 0; age = 0;
        cur = '0;
        cur.lvl_chk = 1;
        repeat (2) @(posedge clk_in);
        #2 srst_in = 0;
        #10 cmp(32'({busy_out, op_complete_out, res_out, volt_out}),
                32'h0000_0004);
        $display("test reset done");
        cur.err = CCS_ERR_SEQUENCE;
        send(CCS_CMD_STORE_ADC, 0, 0, 0, 0);
        clr_err();
        initiated = 1;
        cur.err = CCS_ERR_INIT;
        send(CCS_CMD_CONF_VOLT, 32'h000F_4240, 0, 1, 0);
        initiated = 0;
        clr_err();
        for (int k = 0; k < 2; k++) begin
            cur.err = CCS_ERR_RANGE;
            send(CCS_CMD_CONF_VOLT, k ? 32'h0110_0000 : 32'h0010_2CA0,
                 0, 1, 0);
            clr_err();
        end
        cur.err = CCS_ERR_SEQUENCE;
        send(CCS_CMD_VAL_VOLT, 32'h0000_1234, 0, 0, 0);
        clr_err();
        $display("test refusals done");
        cur.res = 1; cur.lvl_chk = 0;
        send(CCS_CMD_CONF_RES, 0, 0, 0, 0);
        cur.ohms = $random(seed);
        send(CCS_CMD_VAL_RES, cur.ohms, 0, 0, 0);
        $display("test resistor done");
        for (int i = 0; i < CCS_NUM_RANGES; i++) begin
            for (int z = 0; z < 2; z++) begin
                p = (i % 2 == 0) ? 0 : ($random(seed) % 4);
                rv = CCS_RANGE_UV[i] + (CCS_RANGE_UV[i] / 100) * p;
                mvs = (i == 3);
                cur.res = 0; cur.volt = 1; cur.lvl_chk = 1;
                cur.lvl = (z == 0) ? 32'h0000_0000 : (i == 4) ?
                          32'h0098_9680 : CCS_RANGE_UV[i] / 10 * 9;
                send(CCS_CMD_CONF_VOLT, mvs ? rv / 1000 : rv, mvs, z[0],
                     i == 0 && z == 0);
                if (z == 1) cur.gains[i] = 1;
                send(CCS_CMD_VAL_VOLT, $random(seed), 0, 0, 0);
            end
        end
        cur.volt = 0;
        send(CCS_CMD_STORE_ADC, 0, 0, 0, 0);
        $display("test voltage ranges done");
        send(CCS_CMD_ZERO, 0, 0, 0, 0);
        send(CCS_CMD_CHAN_CAL, 0, 0, 0, 0);
        send(CCS_CMD_CHAN_SET, 0, 0, 0, 0);
        send(CCS_CMD_REMOTE, 0, 0, 0, 0);
        short_uv = $random(seed);
        cur.tare = short_uv;
        send(CCS_CMD_TARE, 0, 0, 0, 0);
        st_tare = 1;
        short_uv = ~short_uv;
        send(CCS_CMD_TARE, 0, 0, 0, 0);
        st_tare = 0;
        $display("test working cal done");
        complete_run();
    end
endmodule
`default_nettype wire
